// ---- rtl/sbrp_pkg.sv ----
// Package for the subcarrier bandwidth request poll responder
package sbrp_pkg;

  // ==========================================================================
  // Geometry defaults
  localparam int SBRP_DATA_TONES_DEF   = 48;
  localparam int SBRP_TONES_PER_STA    = 4;
  localparam int SBRP_MAX_STATIONS_DEF = 96;
  localparam int SBRP_IDX_W_DEF        = 8;

  // ==========================================================================
  // Poll modes and per-tone actions
  typedef enum logic [0:0] {
    SBRP_MODE_OOK,
    SBRP_MODE_DBPSK
  } sbrp_mode_t;

  typedef enum logic [1:0] {
    SBRP_TONE_IDLE,
    SBRP_TONE_ON,
    SBRP_TONE_REF,
    SBRP_TONE_FLIP
  } sbrp_tone_t;

  localparam logic [0:0] SBRP_PHASE_REF  = 1'h0;
  localparam logic [0:0] SBRP_PHASE_FLIP = 1'h1;

  // ==========================================================================
  // Poll descriptor from the downlink parser
  typedef struct packed {
    sbrp_mode_t  mode;
    logic        want_bw;
    logic [15:0] rand_num;
  } sbrp_poll_t;

  // Tone request from the uplink symbol mapper
  typedef struct packed {
    logic [15:0] symbol;
    logic [15:0] tone;
  } sbrp_slot_t;

endpackage : sbrp_pkg

// ---- rtl/sbrp_poll_responder.sv ----
// Subcarrier bandwidth request poll responder, subscriber station side
//==============================================================================
// Overview of operation
// - On-off mode energizes every tone of the station's set when it wants bandwidth, else leaves them empty.
// - The on-off region spans tones_per_station*max_stations/data_tones symbols on a grid data_tones/tones_per_station apart.
// - In on-off mode the intermediate value is (random number + station index) mod max_stations.
// - Symbol number is the intermediate value divided by the grid spacing, grid position is its remainder.
// - In differential mode one request bit is sent, 1 asking for a unicast poll and 0 asking nothing.
// - A differential slot is one tone over two consecutive symbols, the first being the phase reference.
// - The second symbol keeps the reference phase for no request and inverts it by 180 degrees for a request.
// - The differential region holds the slots over 2*ceil(max_stations/data_tones) symbols, tone first then symbol.
// - Differential slot is (station index + random number) mod data_tones*ceil(max_stations/data_tones).
`timescale 1ns/1ps
`default_nettype none

module sbrp_poll_responder
  import sbrp_pkg::*;
#(
  parameter int DATA_TONES   = SBRP_DATA_TONES_DEF,
  parameter int TONES_PER_ST = SBRP_TONES_PER_STA,
  parameter int MAX_STATIONS = SBRP_MAX_STATIONS_DEF
) (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic [15:0] station_index,
  input  wire logic        poll_valid,
  input  wire sbrp_poll_t  poll,
  input  wire logic        slot_query,
  input  wire sbrp_slot_t  slot,
  output logic             alloc_valid,
  output logic [15:0]      alloc_symbol,
  output logic [15:0]      alloc_grid,
  output logic             tone_valid,
  output sbrp_tone_t       tone_action,
  output logic [0:0]       tone_phase
);

  // ============================================================================
  // Region geometry
  localparam int GRID_SPACING = DATA_TONES / TONES_PER_ST;
  localparam int DIFF_ROWS    = (MAX_STATIONS + DATA_TONES - 1) / DATA_TONES;
  localparam int DIFF_SLOTS   = DATA_TONES * DIFF_ROWS;
  localparam int OOK_SYMBOLS  = TONES_PER_ST * MAX_STATIONS / DATA_TONES;
  localparam int DIFF_SYMBOLS = 2 * DIFF_ROWS;

  localparam logic [16:0] MAX_ST_W = 17'(MAX_STATIONS);
  localparam logic [16:0] SLOTS_W  = 17'(DIFF_SLOTS);
  localparam logic [15:0] GRID_W   = 16'(GRID_SPACING);
  localparam logic [15:0] TONES_W  = 16'(DATA_TONES);
  localparam logic [15:0] OOK_SYM_W  = 16'(OOK_SYMBOLS);
  localparam logic [15:0] DIFF_SYM_W = 16'(DIFF_SYMBOLS);

  // Sum of two values below the modulus, reduced by one subtraction
  function automatic logic [15:0] sbrp_addmod(input logic [15:0] a,
                                              input logic [15:0] b,
                                              input logic [16:0] m);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (s >= m) begin
      s = s - m;
    end
    return s[15:0];
  endfunction : sbrp_addmod

  // ============================================================================
  // Position arithmetic, recomputed from each fresh poll
  wire logic [15:0] ook_n      = sbrp_addmod(poll.rand_num, station_index,
                                             MAX_ST_W);
  wire logic [15:0] ook_symbol = ook_n / GRID_W;
  wire logic [15:0] ook_grid   = ook_n % GRID_W;
  wire logic [15:0] diff_pos   = sbrp_addmod(station_index, poll.rand_num,
                                             SLOTS_W);
  wire logic [15:0] diff_tone  = diff_pos % TONES_W;
  wire logic [15:0] diff_row   = diff_pos / TONES_W;

  // ============================================================================
  // Next allocation, chosen by the mode of the poll being taken
  // Both positions are always computed so that the mode switch costs no cycle
  wire logic        poll_ook   = poll.mode == SBRP_MODE_OOK;
  wire logic [15:0] nxt_sym    = poll_ook ? ook_symbol : diff_row;
  wire logic [15:0] nxt_grid   = poll_ook ? ook_grid : diff_tone;

  // ============================================================================
  // Latched allocation
  logic             alloc_valid_ff;
  sbrp_mode_t       mode_ff;
  logic             want_ff;
  logic [15:0]      sym_ff;
  logic [15:0]      grid_ff;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      alloc_valid_ff <= 1'b0;
      mode_ff        <= SBRP_MODE_OOK;
      want_ff        <= 1'b0;
      sym_ff         <= 16'h0000;
      grid_ff        <= 16'h0000;
    end else if (poll_valid) begin
      alloc_valid_ff <= 1'b1;
      mode_ff        <= poll.mode;
      want_ff        <= poll.want_bw;
      sym_ff         <= nxt_sym;
      grid_ff        <= nxt_grid;
    end
  end

  // ============================================================================
  // Tone decision for the mapper
  wire logic        ook_in_rgn  = slot.symbol < OOK_SYM_W;
  wire logic        ook_hit     = ook_in_rgn && slot.symbol == sym_ff &&
                                  (slot.tone % GRID_W) == grid_ff;
  wire logic        diff_in_rgn = slot.symbol < DIFF_SYM_W;
  wire logic [15:0] diff_sym0   = {sym_ff[14:0], 1'b0};
  wire logic        diff_tone_h = diff_in_rgn && slot.tone == grid_ff;
  wire logic        diff_ref    = diff_tone_h && slot.symbol == diff_sym0;
  wire logic        diff_data   = diff_tone_h &&
                                  slot.symbol == diff_sym0 + 16'h0001;

  sbrp_tone_t       nxt_action;
  logic [0:0]       nxt_phase;

  always_comb begin
    nxt_action = SBRP_TONE_IDLE;
    nxt_phase  = SBRP_PHASE_REF;
    if (alloc_valid_ff) begin
      if (mode_ff == SBRP_MODE_OOK) begin
        if (ook_hit && want_ff) begin
          nxt_action = SBRP_TONE_ON;
        end
      end else if (diff_ref) begin
        nxt_action = SBRP_TONE_REF;
      end else if (diff_data) begin
        nxt_action = want_ff ? SBRP_TONE_FLIP : SBRP_TONE_REF;
        nxt_phase  = want_ff ? SBRP_PHASE_FLIP : SBRP_PHASE_REF;
      end
    end
  end

  // ============================================================================
  // Answer registers
  // A query in the poll cycle would mix old and new positions, so it is idle
  wire sbrp_tone_t  nxt_tone_act = poll_valid ? SBRP_TONE_IDLE : nxt_action;
  wire logic [0:0]  nxt_tone_ph  = poll_valid ? SBRP_PHASE_REF : nxt_phase;

  logic             tone_valid_ff;
  sbrp_tone_t       tone_action_ff;
  logic [0:0]       tone_phase_ff;

  // A poll arriving with a query wins: the old slot is dropped at once
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      tone_valid_ff  <= 1'b0;
      tone_action_ff <= SBRP_TONE_IDLE;
      tone_phase_ff  <= SBRP_PHASE_REF;
    end else begin
      tone_valid_ff  <= slot_query;
      tone_action_ff <= nxt_tone_act;
      tone_phase_ff  <= nxt_tone_ph;
    end
  end

  assign alloc_valid  = alloc_valid_ff;
  assign alloc_symbol = sym_ff;
  assign alloc_grid   = grid_ff;
  assign tone_valid   = tone_valid_ff;
  assign tone_action  = tone_action_ff;
  assign tone_phase   = tone_phase_ff;

endmodule : sbrp_poll_responder

`default_nettype wire

// ---- tb/sbrp_chk_properties.sv ----
// Port checker for the poll responder
`timescale 1ns/1ps
`default_nettype none
module sbrp_chk
  import sbrp_pkg::*;
#(
  parameter int DATA_TONES   = 48,
  parameter int TONES_PER_ST = 4,
  parameter int MAX_STATIONS = 96
) (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [15:0] station_index,
  input wire logic        poll_valid,
  input wire sbrp_poll_t  poll,
  input wire logic        slot_query,
  input wire logic        alloc_valid,
  input wire logic [15:0] alloc_symbol,
  input wire logic [15:0] alloc_grid,
  input wire logic        tone_valid,
  input wire sbrp_tone_t  tone_action,
  input wire logic [0:0]  tone_phase
);
  localparam int G  = DATA_TONES / TONES_PER_ST;
  localparam int NS = DATA_TONES * ((MAX_STATIONS + DATA_TONES - 1) / DATA_TONES);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Assertions
  chk_tone_pulse: assert property (slot_query |=> tone_valid)
    else $error("no tone answer after query");
  chk_tone_quiet: assert property (!slot_query |=> !tone_valid)
    else $error("tone answer without query");
  chk_ook_symbol: assert property (poll_valid && poll.mode == SBRP_MODE_OOK |=>
    alloc_symbol == ($past(poll.rand_num) + $past(station_index)) % MAX_STATIONS / G)
    else $error("on-off symbol number wrong");
  chk_ook_grid: assert property (poll_valid && poll.mode == SBRP_MODE_OOK |=>
    alloc_grid == ($past(poll.rand_num) + $past(station_index)) % MAX_STATIONS % G)
    else $error("on-off grid number wrong");
  chk_dbpsk_row: assert property (poll_valid && poll.mode == SBRP_MODE_DBPSK |=>
    alloc_symbol == ($past(poll.rand_num) + $past(station_index)) % NS / DATA_TONES)
    else $error("differential slot row wrong");
  chk_dbpsk_tone: assert property (poll_valid && poll.mode == SBRP_MODE_DBPSK |=>
    alloc_grid == ($past(poll.rand_num) + $past(station_index)) % NS % DATA_TONES)
    else $error("differential slot tone wrong");
  chk_phase_flip: assert property (tone_valid && tone_phase |-> tone_action == SBRP_TONE_FLIP)
    else $error("phase inversion outside flip");
  chk_alloc_hold: assert property (!poll_valid |=> $stable(alloc_symbol) && $stable(alloc_grid))
    else $error("allocation changed without poll");
  chk_alloc_set: assert property (poll_valid |=> alloc_valid)
    else $error("allocation not flagged after poll");
endmodule : sbrp_chk
bind sbrp_poll_responder sbrp_chk #(.DATA_TONES(DATA_TONES), .TONES_PER_ST(TONES_PER_ST),
  .MAX_STATIONS(MAX_STATIONS)) u_chk (.*);
`default_nettype wire

// ---- tb/sbrp_bs_model.sv ----
// Base station model: issues polls and counts unicast polls owed
`timescale 1ns/1ps
`default_nettype none
module sbrp_bs_model
  import sbrp_pkg::*;
(
  input wire logic   mclk,
  output logic       poll_valid,
  output sbrp_poll_t poll,
  input wire logic   tone_valid,
  input wire sbrp_tone_t tone_action,
  output logic [15:0] ucnt
);
  logic [15:0] cnt_ff = 16'h0000;
  assign ucnt = cnt_ff;
  initial poll_valid = 1'b0;
  initial poll = '0;
  // Energy or flipped phase means a unicast poll is owed
  always @(posedge mclk) if (tone_valid === 1'b1 && tone_action[0] === 1'b1) cnt_ff <= cnt_ff + 16'h0001;
  // Fresh random number per poll; released field shows its inverse
  task issue(input sbrp_mode_t m, input logic w, input logic [15:0] r);
    @(posedge mclk);
    #1;
    poll_valid = 1'b1;
    poll = '{m, w, r};
    @(posedge mclk);
    #1;
    poll_valid = 1'b0;
    poll.rand_num = ~r;
  endtask : issue
endmodule : sbrp_bs_model
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the poll responder
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import sbrp_pkg::*;
  localparam int DT = 48, TP = 4, MX = 96, G = DT / TP, NS = DT * ((MX + DT - 1) / DT);
  logic mclk = 1'b0, rst = 1'b1, slot_query = 1'b0, poll_valid, alloc_valid, tone_valid, wb;
  logic [15:0] station_index = 16'h0000, alloc_symbol, alloc_grid, ucnt;
  sbrp_slot_t slot = '0;
  sbrp_poll_t poll;
  sbrp_tone_t tone_action;
  sbrp_mode_t md;
  logic [0:0] tone_phase;
  logic [2:0] exp_q[$];
  int n_errors = 0, total_checks = 0, seed = 32'hE1E5544B, exp_uc = 0, r, s;
  always #2.5 mclk = ~mclk;
  sbrp_poll_responder dut (.mclk(mclk), .rst(rst), .station_index(station_index),
    .poll_valid(poll_valid), .poll(poll), .slot_query(slot_query), .slot(slot),
    .alloc_valid(alloc_valid), .alloc_symbol(alloc_symbol), .alloc_grid(alloc_grid),
    .tone_valid(tone_valid), .tone_action(tone_action), .tone_phase(tone_phase));
  sbrp_bs_model bs (.mclk(mclk), .poll_valid(poll_valid), .poll(poll),
    .tone_valid(tone_valid), .tone_action(tone_action), .ucnt(ucnt));
  task check(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  // Returns {phase, action}
  function automatic logic [2:0] model(int sym, int tn);
    int n = (r + s) % MX;
    int p = (r + s) % NS;
    if (md == SBRP_MODE_OOK)
      return (wb && sym == n / G && tn % G == n % G && sym < TP * MX / DT) ? 3'h1 : 3'h0;
    if (tn != p % DT) return 3'h0;
    if (sym == 2 * (p / DT)) return 3'h2;
    if (sym == 2 * (p / DT) + 1) return wb ? 3'h7 : 3'h2;
    return 3'h0;
  endfunction : model
  task query(input int sym, input int tn, input logic [2:0] e);
    @(posedge mclk);
    #1;
    slot_query = 1'b1;
    slot = '{sym[15:0], tn[15:0]};
    exp_q.push_back(e);
    if (e[0]) exp_uc++;
  endtask : query
  task idle();
    @(posedge mclk);
    #1;
    slot_query = 1'b0;
  endtask : idle
  task print_verdict();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict
  always @(negedge mclk) if (tone_valid === 1'b1) check(16'(exp_q.pop_front()), 16'({tone_phase, tone_action}));
  initial begin
    #200000;
    n_errors++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge mclk);
    #1;
    rst = 1'b0;
    s = $unsigned($random(seed)) % MX;
    station_index = s[15:0];
    check(16'(alloc_valid), 16'h0000);
    query(5, 7, 3'h0);
    idle();
    for (int i = 0; i < 40; i++) begin
      md = sbrp_mode_t'(i % 2);
      wb = $random(seed) % 2 != 0;
      r = (i == 2) ? MX - 1 : $unsigned($random(seed)) % MX;
      // Query in the poll cycle is refused and answered idle
      fork
        bs.issue(md, wb, r[15:0]);
        begin query(0, 0, 3'h0); idle(); end
      join
      check(alloc_symbol, 16'(md == SBRP_MODE_OOK ? (r + s) % MX / G : (r + s) % NS / DT));
      check(alloc_grid, 16'(md == SBRP_MODE_OOK ? (r + s) % MX % G : (r + s) % NS % DT));
      check(16'(alloc_valid), 16'h0001);
      for (int y = 0; y < 9; y++) for (int t = 0; t < DT; t++) query(y, t, model(y, t));
      idle();
      $display("poll %0d done", i);
    end
    repeat (3) @(posedge mclk);
    check(ucnt, 16'(exp_uc));
    check(16'(exp_q.size()), 16'h0000);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
